/* File: fbop_ctrl.sv */
`timescale 1ns/1ps
module fbop_ctrl
    import fbop_pkg::*;
(
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    // Request side
    input  wire logic              req_valid_i,
    input  wire fbop_req_s         req_i,
    input  wire logic              protect_en_i,
    output logic                   req_ready_o,
    output logic                   done_o,
    output logic [DATA_W-1:0]      rdata_o,
    output logic [SECT_W-1:0]      sector_o,
    // Flash pins
    output logic [ADDR_W-1:0]      addr_o,
    output logic                   chip_sel_n_o,
    output logic                   out_gate_n_o,
    output logic                   wr_strobe_n_o,
    output logic                   hw_reset_n_o,
    output logic                   word_mode_o,
    output logic                   protect_accel_pin_o,
    output logic [DATA_W-1:0]      dq_o,
    output logic [DATA_W-1:0]      dq_oe_o,
    input  wire logic [DATA_W-1:0] dq_i
);
    fbop_state_e       state_r;   // Sequencer state
    logic [CNT_W-1:0]  cnt_r;     // Phase timer
    fbop_req_s         cur_r;     // Accepted request
    logic [DATA_W-1:0] dq_s1_r;   // Pin sync stage one
    logic [DATA_W-1:0] dq_s2_r;   // Pin sync stage two

    // Read data synchroniser
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            dq_s1_r <= 16'h0000;
            dq_s2_r <= 16'h0000;
        end else begin
            dq_s1_r <= dq_i;
            dq_s2_r <= dq_s1_r;
        end
    end

    // Sequencer and pin drive
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_r             <= ST_IDLE;
            cnt_r               <= '0;
            cur_r               <= '0;
            req_ready_o         <= 1'b0;
            done_o              <= 1'b0;
            rdata_o             <= 16'h0000;
            sector_o            <= '0;
            addr_o              <= '0;
            chip_sel_n_o        <= 1'b1;
            out_gate_n_o        <= 1'b1;
            wr_strobe_n_o       <= 1'b1;
            hw_reset_n_o        <= 1'b1;
            word_mode_o         <= 1'b1;
            protect_accel_pin_o <= 1'b1;
            dq_o                <= 16'h0000;
            dq_oe_o             <= 16'h0000;
        end else begin
            done_o              <= 1'b0;
            protect_accel_pin_o <= ~protect_en_i;
            case (state_r)
                // Wait for a request
                ST_IDLE: begin
                    req_ready_o <= 1'b1;
                    if (req_valid_i && req_ready_o) begin
                        req_ready_o <= 1'b0;
                        cur_r       <= req_i;
                        cnt_r       <= '0;
                        word_mode_o <= ~req_i.byte_mode;
                        sector_o    <= req_i.addr[ADDR_W-1:SECT_LSB];
                        if (req_i.op == OP_RESET) begin
                            hw_reset_n_o <= 1'b0;
                            dq_oe_o      <= 16'h0000;
                            state_r      <= ST_RESET;
                        end else begin
                            addr_o  <= req_i.addr;
                            state_r <= ST_SETUP;
                            if (req_i.op == OP_WRITE) begin
                                dq_o <= req_i.wdata;
                                // Byte mode: upper byte stays off except byte bit
                                dq_oe_o <= req_i.byte_mode ? 16'h00FF : 16'hFFFF;
                            end else begin
                                // Reads: only byte bit driven in byte mode
                                dq_o    <= {req_i.addr[0], 15'h0000};
                                dq_oe_o <= req_i.byte_mode ? 16'h8000 : 16'h0000;
                            end
                            if (req_i.byte_mode && req_i.op == OP_WRITE) begin
                                dq_o[DATA_W-1] <= req_i.addr[0];
                                dq_oe_o        <= 16'h80FF;
                            end
                        end
                    end
                end
                // Address settles, then select falls
                ST_SETUP: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(SETUP_CYC - 1)) begin
                        cnt_r         <= '0;
                        chip_sel_n_o  <= 1'b0;
                        out_gate_n_o  <= (cur_r.op != OP_READ);
                        wr_strobe_n_o <= (cur_r.op == OP_READ);
                        state_r       <= ST_STROBE;
                    end
                end
                // Hold strobes through access time
                ST_STROBE: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(ACC_CYC - 1)) begin
                        cnt_r         <= '0;
                        rdata_o       <= cur_r.byte_mode ? {8'h00, dq_s2_r[7:0]} : dq_s2_r;
                        out_gate_n_o  <= 1'b1;
                        wr_strobe_n_o <= 1'b1;
                        state_r       <= ST_HOLD;
                    end
                end
                // Release select and bus
                ST_HOLD: begin
                    chip_sel_n_o <= 1'b1;
                    dq_oe_o      <= 16'h0000;
                    done_o       <= 1'b1;
                    state_r      <= ST_IDLE;
                end
                // Hold hardware reset low
                ST_RESET: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == CNT_W'(RST_CYC - 1)) begin
                        hw_reset_n_o <= 1'b1;
                        done_o       <= 1'b1;
                        state_r      <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Read never drives the low data byte
    read_float_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !out_gate_n_o |-> dq_oe_o[7:0] == 8'h00) else $error("drive during read");
    // Strobes never both low
    strobe_excl_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !(~out_gate_n_o && ~wr_strobe_n_o)) else $error("gate and strobe low");
    // Strobes only with select low
    strobe_sel_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (!out_gate_n_o || !wr_strobe_n_o) |-> !chip_sel_n_o) else $error("strobe w/o sel");
    // Reset pin low means bus quiet
    reset_quiet_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !hw_reset_n_o |-> chip_sel_n_o && dq_oe_o == 16'h0000) else $error("busy in reset");
    // Reset pulse ends in time
    reset_len_a: assert property (@(posedge clock_i) disable iff (rst_i)
        $fell(hw_reset_n_o) |-> ##[1:130] hw_reset_n_o) else $error("reset too long");
    // Protect pin follows request
    protect_pin_a: assert property (@(posedge clock_i) disable iff (rst_i)
        protect_accel_pin_o == !$past(protect_en_i)) else $error("protect pin wrong");
    // Byte mode upper lines below the top byte-bit line float
    byte_float_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !word_mode_o |-> dq_oe_o[14:8] == 7'h00) else $error("upper lines driven");
    // Select low lasts at least eight cycles
    sel_len_a: assert property (@(posedge clock_i) disable iff (rst_i)
        $fell(chip_sel_n_o) |-> !chip_sel_n_o [*8]) else $error("select too short");
endmodule

/* File: fbop_pkg.sv */
// Notes on behaviour
// - Non-read operations start with command writes; a write here is one bus write cycle and reset only pulses the reset pin
// - Bad sequence recovered by pulsing reset low
// - Byte mode: top data line carries byte bit
// - Host drives word address, byte bit below; byte mode here drives addr_o unshifted, so its bit 0 repeats the byte bit
// - Host and device agree data direction
// - Read: address, select and gate low, strobe high
package fbop_pkg;
    // Bus widths
    localparam int ADDR_W = 26;
    localparam int DATA_W = 16;
    localparam int SECT_LSB = 16;
    localparam int SECT_W = ADDR_W - SECT_LSB;
    localparam int BUF_WORDS = 32;
    localparam int SECURE_WORDS = 128;
    // Timing in ns and derived cycles at 250 MHz
    localparam int CLK_NS = 4;
    localparam int ACC_NS = 90;
    localparam int SETUP_NS = 20;
    localparam int RST_NS = 500;
    localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;
    // Request kinds
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_RESET = 2'h2;
    // Host request bundle
    typedef struct packed {
        logic [1:0]        op;
        logic              byte_mode;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fbop_req_s;
    // Controller states
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_SETUP  = 5'h02,
        ST_STROBE = 5'h04,
        ST_HOLD   = 5'h08,
        ST_RESET  = 5'h10
    } fbop_state_e;
endpackage

/* File: fbop_flash_model.sv */
`timescale 1ns/1ps
module fbop_flash_model (
    // Pins from the controller
    input  wire logic [25:0] addr_i,
    input  wire logic        cs_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        rst_n_i,
    input  wire logic        word_i,
    input  wire logic        prot_i,
    input  wire logic [15:0] bus_i,
    // Data driven back
    output logic      [15:0] dq_o
);
    logic [15:0] mem [16];     // Small array, erased pattern at start
    logic [25:0] lat_r;        // Address taken at select fall
    logic        tog = 1'b0;   // Released lines keep changing, no pull
    logic        rd;           // Read decode
    logic [15:0] w;            // Addressed word
    initial foreach (mem[i]) mem[i] = 16'h5AC3;
    always #4 tog = ~tog;
    // Address capture on select fall
    always @(negedge cs_n_i) lat_r = addr_i;
    // Write taken on strobe rise; top sector refused while pin low
    always @(posedge we_n_i)
        if (!cs_n_i && oe_n_i && rst_n_i && !(!prot_i && &lat_r[25:16]))
            mem[lat_r[3:0]] = bus_i;
    assign rd = rst_n_i && !cs_n_i && !oe_n_i && we_n_i;
    assign w = mem[lat_r[3:0]];
    // Word drives all lines, byte picks by top line, else floats
    always_comb
        if (!rd) dq_o = 16'hA5A5 ^ {16{tog}};
        else if (word_i) dq_o = w;
        else dq_o = {8'hA5 ^ {8{tog}}, bus_i[15] ? w[15:8] : w[7:0]};
endmodule

/* File: flash_bus_operation_decode_tb.sv */
`timescale 1ns/1ps
module flash_bus_operation_decode_tb
    import fbop_pkg::*;
;
    logic              clock_i, rst_i, req_valid_i, protect_en_i, req_ready_o, done_o;
    fbop_req_s         req_i;
    logic [DATA_W-1:0] rdata_o, dq_o, dq_oe_o, dq_i, mdl_dq, mid_oe;
    logic [SECT_W-1:0] sector_o;
    logic [ADDR_W-1:0] addr_o;
    logic              cs_n, oe_n, we_n, hr_n, word_mode_o, prot_pin;
    logic [3:0]        mid_ctl;   // Select, gate, strobe, reset seen mid-op
    int                n_errors = 0, compares = 0, cycles = 0, lat;
    // Resolved data bus
    assign dq_i = (dq_oe_o & dq_o) | (~dq_oe_o & mdl_dq);
    fbop_ctrl dut_u (.clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .protect_en_i(protect_en_i), .req_ready_o(req_ready_o),
        .done_o(done_o), .rdata_o(rdata_o), .sector_o(sector_o), .addr_o(addr_o),
        .chip_sel_n_o(cs_n), .out_gate_n_o(oe_n), .wr_strobe_n_o(we_n),
        .hw_reset_n_o(hr_n), .word_mode_o(word_mode_o), .protect_accel_pin_o(prot_pin),
        .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_i));
    fbop_flash_model mdl_u (.addr_i(addr_o), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .rst_n_i(hr_n), .word_i(word_mode_o), .prot_i(prot_pin), .bus_i(dq_i), .dq_o(mdl_dq));
    // Clock and hang guard
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles++;
        if (cycles >= 5000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One request, waits for done, samples pins mid-way
    task automatic do_op(input logic [1:0] op, input logic bm, input logic [25:0] a,
                         input logic [15:0] d);
        @(negedge clock_i);
        req_i = '{op: op, byte_mode: bm, addr: a, wdata: d};
        req_valid_i = 1'b1;
        while (req_ready_o !== 1'b1) @(negedge clock_i);
        @(negedge clock_i);
        req_valid_i = 1'b0;
        lat = 1;
        while (done_o !== 1'b1) begin
            @(negedge clock_i);
            lat++;
            if (lat == 15) begin
                mid_ctl = {cs_n, oe_n, we_n, hr_n};
                mid_oe = dq_oe_o;
            end
        end
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        rst_i = 1'b1;
        req_valid_i = 1'b0;
        protect_en_i = 1'b0;
        req_i = '0;
        repeat (6) @(negedge clock_i);
        rst_i = 1'b0;
        @(negedge clock_i);
        chk({10'h0, cs_n, oe_n, we_n, hr_n, word_mode_o, prot_pin}, 16'h003F);
        chk(dq_oe_o, 16'h0000);
        $display("test idle done");
        do_op(OP_WRITE, 1'b0, 26'h3FF0006, 16'h1234);
        chk({12'h0, mid_ctl}, 16'h0005);
        chk(mid_oe, 16'hFFFF);
        chk({6'h0, sector_o}, 16'h03FF);
        chk(addr_o[15:0], 16'h0006);
        do_op(OP_READ, 1'b0, 26'h3FF0006, 16'h0000);
        chk({12'h0, mid_ctl}, 16'h0003);
        chk(mid_oe, 16'h0000);
        chk(rdata_o, 16'h1234);
        $display("test word done");
        protect_en_i = 1'b1;
        do_op(OP_WRITE, 1'b0, 26'h3FF0007, 16'hBEEF);
        chk({15'h0, prot_pin}, 16'h0000);
        do_op(OP_READ, 1'b0, 26'h3FF0007, 16'h0000);
        chk(rdata_o, 16'h5AC3);
        protect_en_i = 1'b0;
        repeat (2) @(negedge clock_i);
        chk({15'h0, prot_pin}, 16'h0001);
        $display("test protect done");
        do_op(OP_READ, 1'b1, 26'h0000001, 16'h0000);
        chk(mid_oe, 16'h8000);
        chk({15'h0, word_mode_o}, 16'h0000);
        chk(rdata_o, 16'h005A);
        do_op(OP_READ, 1'b1, 26'h0000000, 16'h0000);
        chk(rdata_o, 16'h00C3);
        $display("test byte done");
        do_op(OP_RESET, 1'b0, 26'h0, 16'h0);
        chk({12'h0, mid_ctl}, 16'h000E);
        chk(mid_oe, 16'h0000);
        chk({15'h0, lat >= RST_CYC}, 16'h0001);
        do_op(OP_READ, 1'b0, 26'h3FF0006, 16'h0000);
        chk(rdata_o, 16'h1234);
        $display("test reset done");
        finish_test();
    end
endmodule
